// *** fvcb_pkg.sv ***
package fvcb_pkg;

	// Byte offsets inside the configuration bank (low address byte only)
	localparam logic [7:0] FVCB_OFS_MODE = 8'h00;
	localparam logic [7:0] FVCB_OFS_DUMMY = 8'h01;
	localparam logic [7:0] FVCB_OFS_DRIVE = 8'h03;
	localparam logic [7:0] FVCB_OFS_ADDR_BYTES = 8'h05;
	localparam logic [7:0] FVCB_OFS_XIP = 8'h06;
	localparam logic [7:0] FVCB_OFS_WRAP = 8'h07;
	localparam logic [7:0] FVCB_OFS_TRAIN = 8'h0a;
	localparam logic [7:0] FVCB_OFS_INTEG = 8'h0b;
	localparam logic [7:0] FVCB_OFS_ECC_STAT = 8'h0c;

	// Values after reset
	localparam logic [7:0] FVCB_RST_MODE = 8'hff;
	localparam logic [7:0] FVCB_RST_DUMMY = 8'h1f;
	localparam logic [7:0] FVCB_RST_DRIVE = 8'hff;
	localparam logic [7:0] FVCB_RST_ADDR_BYTES = 8'hff;
	localparam logic [7:0] FVCB_RST_XIP = 8'hff;
	localparam logic [7:0] FVCB_RST_WRAP = 8'hff;
	localparam logic [7:0] FVCB_RST_TRAIN = 8'h55;
	localparam logic [7:0] FVCB_RST_INTEG = 8'hff;
	localparam logic [7:0] FVCB_RST_UNMAPPED = 8'hff;

	// Interface mode codes
	localparam logic [7:0] FVCB_MODE_XSPI_STROBE = 8'hff;
	localparam logic [7:0] FVCB_MODE_XSPI = 8'hdf;
	localparam logic [7:0] FVCB_MODE_ODDR_STROBE = 8'he7;
	localparam logic [7:0] FVCB_MODE_ODDR = 8'hc7;

	// Two-state byte codes shared by several registers
	localparam logic [7:0] FVCB_CODE_OFF = 8'hff;
	localparam logic [7:0] FVCB_CODE_ON = 8'hfe;

	// Wrap codes
	localparam logic [7:0] FVCB_WRAP_64 = 8'hfe;
	localparam logic [7:0] FVCB_WRAP_32 = 8'hfd;
	localparam logic [7:0] FVCB_WRAP_16 = 8'hfc;

	// Lowest legal drive strength code
	localparam logic [7:0] FVCB_DRIVE_MIN = 8'hfc;

	// Dummy cycle codes and counts
	localparam logic [7:0] FVCB_DUMMY_ALIAS = 8'h00;
	localparam logic [7:0] FVCB_DUMMY_MAX = 8'h1e;
	localparam logic [7:0] FVCB_DUMMY_DEFAULT = 8'h1f;
	localparam logic [5:0] FVCB_DUMMY_DEFAULT_CYC = 6'h12;
	localparam logic [5:0] FVCB_DUMMY_TRAIN_EXTRA = 6'h02;

	// Integrity control bit positions
	localparam int FVCB_BIT_READ_CRC = 7;
	localparam int FVCB_BIT_SSO = 6;
	localparam int FVCB_BIT_CHUNK_HI = 5;
	localparam int FVCB_BIT_CHUNK_LO = 4;
	localparam int FVCB_BIT_PROG_CRC = 3;
	localparam int FVCB_BIT_ERR_SEL = 2;
	localparam int FVCB_BIT_ERR_DIS = 1;
	localparam int FVCB_BIT_ECC_DIS = 0;

	// Event counter saturation value and field position
	localparam logic [3:0] FVCB_ECC_CNT_MAX = 4'hf;
	localparam int FVCB_ECC_CNT_LSB = 3;

	// Training lane that carries the inverted copy
	localparam logic [7:0] FVCB_SSO_MASK = 8'h08;

endpackage

// *** fvcb_bank.sv ***
// Operation
// - Bit 7 clear enables read CRC/parity
// - Bit 6 clear inverts lane three in training
// - Bits 5:4 pick program CRC chunk size
// - Bit 3 clear enables program CRC/parity
// - Bit 2 picks error event type
// - Bit 1 clear lets error pin signal
// - Bit 0 clear turns ECC on
// - Offset 0Ah holds training byte, MSB first
// - Offset 07h selects read wrap length
// - Offset 06h enables execute-in-place mode
// - Offset 05h selects three or four address bytes
// - Offset 01h encodes dummy cycle count
// - Dummy count applies to fast/OTP/training reads
// - Training read adds two dummy cycles
// - Default dummy code means eighteen cycles
// - Offset 00h selects interface mode
// - Octal-boot parts refuse extended SPI modes
// - ECC event counter saturates at fifteen
// - Reserved write ignored, flags error, clears latch
// - Reserved address reads back FFh
// - Reset restores defaults; low address byte selects
module fvcb_bank #(
	parameter bit BOOT_OCTAL_DDR = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic cs_n_i,
	input wire logic link_wr_i,
	input wire logic link_rd_i,
	input wire logic [7:0] link_addr_i,
	input wire logic [7:0] link_wdata_i,
	output logic [7:0] link_rdata_o,
	input wire logic train_read_i,
	input wire logic [2:0] train_bit_i,
	input wire logic ecc_corr_i,
	input wire logic ecc_detect_i,
	output logic reserved_write_o,
	output logic wel_clear_o,
	output logic octal_ddr_o,
	output logic strobe_en_o,
	output logic [5:0] dummy_cycles_o,
	output logic [1:0] drive_sel_o,
	output logic four_byte_addr_o,
	output logic execute_in_place_o,
	output logic [6:0] wrap_bytes_o,
	output logic [7:0] train_dq_o,
	output logic read_crc_disable_o,
	output logic program_crc_disable_o,
	output logic [7:0] program_chunk_size_o,
	output logic error_pin_event_select_o,
	output logic error_pin_disable_o,
	output logic correction_disable_o,
	output logic err_n_o,
	output logic [3:0] correction_event_counter_o
);
	import fvcb_pkg::*;

	// Current bank contents, core domain
	logic [7:0] interface_mode_select_reg;
	logic [7:0] dummy_cycle_count_reg;
	logic [7:0] output_drive_strength_reg;
	logic [7:0] address_byte_count_reg;
	logic [7:0] execute_in_place_enable_reg;
	logic [7:0] read_wrap_length_reg;
	logic [7:0] training_pattern_reg;
	logic [7:0] integrity_check_control_reg;
	logic [3:0] ecc_count_reg; // Saturating event count

	// Link-domain reset synchroniser and write capture
	logic [2:0] link_rst_sync_reg; // Three stages from core reset
	logic link_rst_n; // Link reset, released when both late stages are high
	logic wr_toggle_reg; // Flips once per captured write
	logic [7:0] wr_addr_reg; // Captured write address
	logic [7:0] wr_data_reg; // Captured write data

	// Core-domain synchronisers
	logic [2:0] tog_sync_reg; // Write toggle, three stages
	logic tog_seen_reg; // Toggle level already taken
	logic [2:0] cs_sync_reg; // Chip select, three stages
	logic frame_idle; // Chip select high on both late stages
	logic new_write; // Fresh write arrived this cycle

	// Staged write waiting for the command to end
	logic pend_reg;
	logic [7:0] pend_addr_reg;
	logic [7:0] pend_data_reg;
	logic commit;

	// Error pin and event counter sources
	logic err_event;
	logic ecc_event;

	// Legal value check per register; unmapped addresses never pass
	function automatic logic value_legal(input logic [7:0] a, input logic [7:0] d);
		unique case (a)
			FVCB_OFS_MODE: begin
				if (BOOT_OCTAL_DDR) begin
					value_legal = (d == FVCB_MODE_ODDR_STROBE);
				end else begin
					value_legal = (d == FVCB_MODE_XSPI_STROBE) || (d == FVCB_MODE_XSPI) ||
						(d == FVCB_MODE_ODDR_STROBE) || (d == FVCB_MODE_ODDR);
				end
			end
			FVCB_OFS_DUMMY: begin
				value_legal = (d <= FVCB_DUMMY_DEFAULT);
			end
			// Four drive strengths
			FVCB_OFS_DRIVE: begin
				value_legal = (d >= FVCB_DRIVE_MIN);
			end
			FVCB_OFS_ADDR_BYTES, FVCB_OFS_XIP: begin
				value_legal = (d == FVCB_CODE_OFF) || (d == FVCB_CODE_ON);
			end
			FVCB_OFS_WRAP: begin
				value_legal = (d >= FVCB_WRAP_16);
			end
			// Any byte is a valid pattern or control
			FVCB_OFS_TRAIN, FVCB_OFS_INTEG: begin
				value_legal = 1'b1;
			end
			default: begin
				value_legal = 1'b0;
			end
		endcase
	endfunction

	// Read mux, also used for the status byte
	function automatic logic [7:0] read_value(input logic [7:0] a);
		// Only the low address byte decodes
		unique case (a)
			FVCB_OFS_MODE: read_value = interface_mode_select_reg;
			FVCB_OFS_DUMMY: read_value = dummy_cycle_count_reg;
			FVCB_OFS_DRIVE: read_value = output_drive_strength_reg;
			FVCB_OFS_ADDR_BYTES: read_value = address_byte_count_reg;
			FVCB_OFS_XIP: read_value = execute_in_place_enable_reg;
			FVCB_OFS_WRAP: read_value = read_wrap_length_reg;
			FVCB_OFS_TRAIN: read_value = training_pattern_reg;
			FVCB_OFS_INTEG: read_value = integrity_check_control_reg;
			FVCB_OFS_ECC_STAT: read_value = {1'b0, ecc_count_reg, 3'h0};
			default: read_value = FVCB_RST_UNMAPPED;
		endcase
	endfunction

	// Core reset carried into the link domain
	always_ff @(posedge link_clk_i) begin
		link_rst_sync_reg <= {link_rst_sync_reg[1:0], rst_n_i};
	end

	// Reset held until both late stages show release
	assign link_rst_n = link_rst_sync_reg[2] & link_rst_sync_reg[1];

	// Capture every write cycle and flag it by toggle
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			wr_toggle_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else if (link_wr_i) begin
			// Address and data stay put until the next write
			wr_toggle_reg <= ~wr_toggle_reg;
			wr_addr_reg <= link_addr_i;
			wr_data_reg <= link_wdata_i;
		end
	end

	// Read data sampled from the bank; bank only changes between frames
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			link_rdata_o <= FVCB_RST_UNMAPPED;
		end else if (link_rd_i) begin
			link_rdata_o <= read_value(link_addr_i);
		end
	end

	// Toggle and chip select synchronisers into the core
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tog_sync_reg <= 3'h0;
			cs_sync_reg <= 3'h7;
		end else begin
			tog_sync_reg <= {tog_sync_reg[1:0], wr_toggle_reg};
			cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
		end
	end

	// A change counts once stages two and three agree
	assign new_write = (tog_sync_reg[2] == tog_sync_reg[1]) && (tog_sync_reg[2] != tog_seen_reg);
	assign frame_idle = cs_sync_reg[2] & cs_sync_reg[1];

	// Remember which toggle level was taken
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tog_seen_reg <= 1'b0;
		end else if (new_write) begin
			tog_seen_reg <= tog_sync_reg[2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reserved_write_o <= 1'b0;
			wel_clear_o <= 1'b0;
		end else begin
			// One-cycle pulses toward flag status and write latch
			reserved_write_o <= new_write && !value_legal(wr_addr_reg, wr_data_reg);
			wel_clear_o <= new_write && !value_legal(wr_addr_reg, wr_data_reg);
		end
	end

	// Hold a legal write until the command ends
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pend_reg <= 1'b0;
			pend_addr_reg <= 8'h00;
			pend_data_reg <= 8'h00;
		end else if (new_write && value_legal(wr_addr_reg, wr_data_reg)) begin
			// Newest write replaces any older staged one
			pend_reg <= 1'b1;
			pend_addr_reg <= wr_addr_reg;
			pend_data_reg <= wr_data_reg;
		end else if (commit) begin
			pend_reg <= 1'b0;
		end
	end

	// Apply only while chip select is high
	assign commit = pend_reg && frame_idle;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			interface_mode_select_reg <= FVCB_RST_MODE;
			dummy_cycle_count_reg <= FVCB_RST_DUMMY;
			output_drive_strength_reg <= FVCB_RST_DRIVE;
			address_byte_count_reg <= FVCB_RST_ADDR_BYTES;
			execute_in_place_enable_reg <= FVCB_RST_XIP;
			read_wrap_length_reg <= FVCB_RST_WRAP;
			training_pattern_reg <= FVCB_RST_TRAIN;
			integrity_check_control_reg <= FVCB_RST_INTEG;
		end else if (commit) begin
			// Address already checked when staged
			unique case (pend_addr_reg)
				FVCB_OFS_MODE: interface_mode_select_reg <= pend_data_reg;
				FVCB_OFS_DUMMY: dummy_cycle_count_reg <= pend_data_reg;
				FVCB_OFS_DRIVE: output_drive_strength_reg <= pend_data_reg;
				FVCB_OFS_ADDR_BYTES: address_byte_count_reg <= pend_data_reg;
				FVCB_OFS_XIP: execute_in_place_enable_reg <= pend_data_reg;
				FVCB_OFS_WRAP: read_wrap_length_reg <= pend_data_reg;
				FVCB_OFS_TRAIN: training_pattern_reg <= pend_data_reg;
				FVCB_OFS_INTEG: integrity_check_control_reg <= pend_data_reg;
				default: begin
				end
			endcase
		end
	end

	// Interface mode decode
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			octal_ddr_o <= BOOT_OCTAL_DDR;
			strobe_en_o <= 1'b1;
		end else begin
			// Octal boot always runs octal with strobe
			if (BOOT_OCTAL_DDR) begin
				octal_ddr_o <= 1'b1;
				strobe_en_o <= 1'b1;
			end else begin
				octal_ddr_o <= (interface_mode_select_reg == FVCB_MODE_ODDR_STROBE) ||
					(interface_mode_select_reg == FVCB_MODE_ODDR);
				strobe_en_o <= (interface_mode_select_reg == FVCB_MODE_XSPI_STROBE) ||
					(interface_mode_select_reg == FVCB_MODE_ODDR_STROBE);
			end
		end
	end

	// Dummy count for every read that needs one
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dummy_cycles_o <= FVCB_DUMMY_DEFAULT_CYC;
		end else if ((dummy_cycle_count_reg == FVCB_DUMMY_DEFAULT) ||
			(dummy_cycle_count_reg == FVCB_DUMMY_ALIAS)) begin
			dummy_cycles_o <= train_read_i ? FVCB_DUMMY_DEFAULT_CYC + FVCB_DUMMY_TRAIN_EXTRA :
				FVCB_DUMMY_DEFAULT_CYC;
		end else begin
			// Codes one to thirty are direct
			dummy_cycles_o <= train_read_i ?
				dummy_cycle_count_reg[5:0] + FVCB_DUMMY_TRAIN_EXTRA :
				dummy_cycle_count_reg[5:0];
		end
	end

	// Address width, execute-in-place, wrap and drive decode
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			four_byte_addr_o <= 1'b0;
			execute_in_place_o <= 1'b0;
			wrap_bytes_o <= 7'h00;
			drive_sel_o <= 2'h0;
		end else begin
			// Four bytes only on the enable code
			four_byte_addr_o <= (address_byte_count_reg == FVCB_CODE_ON);
			// Armed here; entry by confirmation bit elsewhere
			execute_in_place_o <= (execute_in_place_enable_reg == FVCB_CODE_ON);
			unique case (read_wrap_length_reg)
				FVCB_WRAP_64: wrap_bytes_o <= 7'h40;
				FVCB_WRAP_32: wrap_bytes_o <= 7'h20;
				FVCB_WRAP_16: wrap_bytes_o <= 7'h10;
				default: wrap_bytes_o <= 7'h00;
			endcase
			// Zero is the default impedance
			drive_sel_o <= ~output_drive_strength_reg[1:0];
		end
	end

	// Integrity control bits out to the datapath
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			read_crc_disable_o <= 1'b1;
			program_crc_disable_o <= 1'b1;
			program_chunk_size_o <= 8'h10;
			error_pin_event_select_o <= 1'b1;
			error_pin_disable_o <= 1'b1;
			correction_disable_o <= 1'b1;
		end else begin
			read_crc_disable_o <= integrity_check_control_reg[FVCB_BIT_READ_CRC];
			program_crc_disable_o <= integrity_check_control_reg[FVCB_BIT_PROG_CRC];
			unique case (integrity_check_control_reg[FVCB_BIT_CHUNK_HI:FVCB_BIT_CHUNK_LO])
				2'b11: program_chunk_size_o <= 8'h10;
				2'b10: program_chunk_size_o <= 8'h20;
				2'b01: program_chunk_size_o <= 8'h40;
				2'b00: program_chunk_size_o <= 8'h80;
			endcase
			error_pin_event_select_o <= integrity_check_control_reg[FVCB_BIT_ERR_SEL];
			error_pin_disable_o <= integrity_check_control_reg[FVCB_BIT_ERR_DIS];
			correction_disable_o <= integrity_check_control_reg[FVCB_BIT_ECC_DIS];
		end
	end

	// Training lanes, lane three inverted when enabled
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			train_dq_o <= 8'h00;
		end else begin
			// Bit index zero picks the MSB
			train_dq_o <= {8{training_pattern_reg[3'h7 - train_bit_i]}} ^
				(integrity_check_control_reg[FVCB_BIT_SSO] ? 8'h00 : FVCB_SSO_MASK);
		end
	end

	// Any event for the counter, selected type for the pin, only while ECC is on
	assign ecc_event = !integrity_check_control_reg[FVCB_BIT_ECC_DIS] && (ecc_corr_i || ecc_detect_i);
	assign err_event = !integrity_check_control_reg[FVCB_BIT_ECC_DIS] &&
		(integrity_check_control_reg[FVCB_BIT_ERR_SEL] ? ecc_detect_i : ecc_corr_i);

	// Error pin low for one cycle per selected event
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			err_n_o <= 1'b1;
		end else begin
			err_n_o <= !(err_event && !integrity_check_control_reg[FVCB_BIT_ERR_DIS]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ecc_count_reg <= 4'h0;
		end else if (ecc_event && (ecc_count_reg != FVCB_ECC_CNT_MAX)) begin
			ecc_count_reg <= ecc_count_reg + 4'h1;
		end
	end

	assign correction_event_counter_o = ecc_count_reg;

endmodule

// *** fvcb_bank_assertions.sv ***
module fvcb_bank_assertions (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic train_read_i,
	input wire logic ecc_corr_i,
	input wire logic ecc_detect_i,
	input wire logic reserved_write_o,
	input wire logic wel_clear_o,
	input wire logic [5:0] dummy_cycles_o,
	input wire logic four_byte_addr_o,
	input wire logic execute_in_place_o,
	input wire logic [6:0] wrap_bytes_o,
	input wire logic [7:0] train_dq_o,
	input wire logic [7:0] program_chunk_size_o,
	input wire logic error_pin_event_select_o,
	input wire logic error_pin_disable_o,
	input wire logic correction_disable_o,
	input wire logic err_n_o,
	input wire logic [3:0] correction_event_counter_o
);
	import fvcb_pkg::*;
	// Selected ECC event with the pin enabled
	logic ecc_hit;
	assign ecc_hit = !error_pin_disable_o && !correction_disable_o &&
		(error_pin_event_select_o ? ecc_detect_i : ecc_corr_i);
	// Any ECC event while correction is on
	logic ecc_any;
	assign ecc_any = !correction_disable_o && (ecc_corr_i || ecc_detect_i);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_reject_pair: assert property (reserved_write_o == wel_clear_o)
		else $error("reject pulse without latch clear");
	a_reject_pulse: assert property (reserved_write_o |=> !reserved_write_o)
		else $error("reject pulse too long");
	a_err_cause: assert property (!err_n_o |-> $past(ecc_hit))
		else $error("error pin low without selected event");
	a_err_fires: assert property (ecc_hit |=> !err_n_o)
		else $error("selected event missed on error pin");
	a_cnt_step: assert property ($changed(correction_event_counter_o)
		|-> correction_event_counter_o == $past(correction_event_counter_o) + 4'h1
		&& $past(ecc_any))
		else $error("event counter moved wrongly");
	a_cnt_sat: assert property (correction_event_counter_o == FVCB_ECC_CNT_MAX
		|=> correction_event_counter_o == FVCB_ECC_CNT_MAX)
		else $error("event counter left saturation");
	a_train_extra: assert property ($rose(train_read_i) |=>
		dummy_cycles_o == $past(dummy_cycles_o) + 6'h02)
		else $error("training dummy not two more");
	a_chunk_legal: assert property (program_chunk_size_o inside
		{8'h10, 8'h20, 8'h40, 8'h80})
		else $error("bad chunk size");
	a_wrap_legal: assert property (wrap_bytes_o inside {7'h00, 7'h10, 7'h20, 7'h40})
		else $error("bad wrap length");
	// lanes equal apart from lane three
	a_lane_match: assert property (((train_dq_o ^ {8{train_dq_o[0]}})
		& ~FVCB_SSO_MASK) == 8'h00)
		else $error("training lanes differ");
	a_frame_hold: assert property ((cs_n_i == 1'b0) [*8] |-> $stable(wrap_bytes_o)
		&& $stable(four_byte_addr_o) && $stable(execute_in_place_o))
		else $error("setting changed mid frame");
	c_reject: cover property (reserved_write_o);
	c_err: cover property (!err_n_o);
	c_sat: cover property (correction_event_counter_o == FVCB_ECC_CNT_MAX && ecc_corr_i);
endmodule

bind fvcb_bank fvcb_bank_assertions u_fvcb_bank_assertions (
	.clk_i, .rst_n_i, .cs_n_i, .train_read_i, .ecc_corr_i, .ecc_detect_i,
	.reserved_write_o, .wel_clear_o, .dummy_cycles_o, .four_byte_addr_o,
	.execute_in_place_o, .wrap_bytes_o, .train_dq_o, .program_chunk_size_o,
	.error_pin_event_select_o, .error_pin_disable_o, .correction_disable_o,
	.err_n_o, .correction_event_counter_o
);

// *** fvcb_host.sv ***
module fvcb_host (
	output logic link_clk_o,
	output logic cs_n_o,
	output logic link_wr_o,
	output logic link_rd_o,
	output logic [7:0] link_addr_o,
	output logic [7:0] link_wdata_o,
	input wire logic [7:0] link_rdata_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle: clock parked, select released
	initial begin
		link_clk_o = 1'b0;
		cs_n_o = 1'b1;
		link_wr_o = 1'b0;
		link_rd_o = 1'b0;
		link_addr_o = 8'ha5;
		link_wdata_o = 8'h5a;
	end
	// Link clock periods; changes land after the fall
	task automatic tick(input int n);
		repeat (n) begin
			#62.5 link_clk_o = 1'b1;
			#62.5 link_clk_o = 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cs_n_o = 1'b0;
		tick(1);
		link_wr_o = 1'b1;
		link_addr_o = a;
		link_wdata_o = d;
		tick(1);
		link_wr_o = 1'b0;
		link_addr_o = ~a;
		link_wdata_o = ~d;
		tick(2);
		cs_n_o = 1'b1;
	endtask
	// Read frame, data one link edge after request
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		cs_n_o = 1'b0;
		tick(1);
		link_rd_o = 1'b1;
		link_addr_o = a;
		tick(1);
		link_rd_o = 1'b0;
		link_addr_o = ~a;
		tick(1);
		d = link_rdata_i;
		tick(1);
		cs_n_o = 1'b1;
	endtask
endmodule

// *** fvcb_bank_tb.sv ***
module fvcb_bank_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fvcb_pkg::*;
	localparam logic [7:0] DEF [16] = '{8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'h55, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff};
	localparam logic [7:0] MODES [4] = '{8'hff, 8'hdf, 8'he7, 8'hc7};
	localparam logic [7:0] MOUT [4] = '{8'h01, 8'h00, 8'h03, 8'h02};
	localparam logic [7:0] DCODE [4] = '{8'h00, 8'h01, 8'h1e, 8'h1f};
	localparam logic [7:0] DCYC [4] = '{8'd18, 8'd1, 8'd30, 8'd18};
	localparam logic [7:0] WCODE [4] = '{8'hfe, 8'hfd, 8'hfc, 8'hff};
	localparam logic [7:0] WLEN [4] = '{8'd64, 8'd32, 8'd16, 8'd0};
	localparam logic [7:0] ECODE [3] = '{8'hfc, 8'hfa, 8'hf9};
	localparam logic [7:0] EHIT [3] = '{8'd1, 8'd0, 8'd0};
	logic clk_i, rst_n_i, train_read_i, ecc_corr_i, ecc_detect_i;
	logic [2:0] train_bit_i;
	logic link_clk_i, cs_n_i, link_wr_i, link_rd_i, reserved_write_o, wel_clear_o;
	logic [7:0] link_addr_i, link_wdata_i, link_rdata_o, train_dq_o, program_chunk_size_o;
	logic octal_ddr_o, strobe_en_o, four_byte_addr_o, execute_in_place_o, err_n_o;
	logic read_crc_disable_o, program_crc_disable_o, error_pin_event_select_o;
	logic error_pin_disable_o, correction_disable_o;
	logic [5:0] dummy_cycles_o;
	logic [1:0] drive_sel_o;
	logic [6:0] wrap_bytes_o;
	logic [3:0] correction_event_counter_o;
	logic [7:0] v;
	logic boot_octal_o, boot_strobe_o; // Octal-boot copy, mode decode
	int num_errors, n_compared, n_rej, n_err, cyc, k;
	fvcb_bank #(.BOOT_OCTAL_DDR(1'b0)) u_fvcb_bank (
		.clk_i, .rst_n_i, .link_clk_i, .cs_n_i, .link_wr_i, .link_rd_i, .link_addr_i,
		.link_wdata_i, .link_rdata_o, .train_read_i, .train_bit_i, .ecc_corr_i,
		.ecc_detect_i, .reserved_write_o, .wel_clear_o, .octal_ddr_o, .strobe_en_o,
		.dummy_cycles_o, .drive_sel_o, .four_byte_addr_o, .execute_in_place_o,
		.wrap_bytes_o, .train_dq_o, .read_crc_disable_o, .program_crc_disable_o,
		.program_chunk_size_o, .error_pin_event_select_o, .error_pin_disable_o,
		.correction_disable_o, .err_n_o, .correction_event_counter_o
	);
	fvcb_host u_fvcb_host (
		.link_clk_o(link_clk_i), .cs_n_o(cs_n_i), .link_wr_o(link_wr_i),
		.link_rd_o(link_rd_i), .link_addr_o(link_addr_i), .link_wdata_o(link_wdata_i),
		.link_rdata_i(link_rdata_o)
	);
	// Octal-boot variant on the same link, mode outputs only
	fvcb_bank #(.BOOT_OCTAL_DDR(1'b1)) u_fvcb_bank_boot (
		.clk_i, .rst_n_i, .link_clk_i, .cs_n_i, .link_wr_i, .link_rd_i, .link_addr_i,
		.link_wdata_i, .link_rdata_o(), .train_read_i, .train_bit_i, .ecc_corr_i,
		.ecc_detect_i, .reserved_write_o(), .wel_clear_o(), .octal_ddr_o(boot_octal_o),
		.strobe_en_o(boot_strobe_o), .dummy_cycles_o(), .drive_sel_o(), .four_byte_addr_o(),
		.execute_in_place_o(), .wrap_bytes_o(), .train_dq_o(), .read_crc_disable_o(),
		.program_crc_disable_o(), .program_chunk_size_o(), .error_pin_event_select_o(),
		.error_pin_disable_o(), .correction_disable_o(), .err_n_o(),
		.correction_event_counter_o()
	);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Pulse counters and run ceiling
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (reserved_write_o === 1'b1)
			n_rej <= n_rej + 1;
		if (err_n_o === 1'b0)
			n_err <= n_err + 1;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Write, then wait out the commit
	task automatic wcfg(input logic [7:0] a, input logic [7:0] d);
		u_fvcb_host.wr(a, d);
		repeat (12) @(posedge clk_i);
		#1;
	endtask
	task automatic rcfg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_fvcb_host.rd(a, d);
		check($sformatf("reg %h", a), d, exp);
	endtask
	// One ECC event pulse
	task automatic ev(input logic c, input logic d);
		@(posedge clk_i);
		ecc_corr_i <= c;
		ecc_detect_i <= d;
		@(posedge clk_i);
		ecc_corr_i <= 1'b0;
		ecc_detect_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	// Reset both domains, then read back every default
	task automatic reset_check();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		u_fvcb_host.tick(4);
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		u_fvcb_host.tick(5);
		for (int i = 0; i < 16; i++)
			rcfg(8'(i), DEF[i]);
		rcfg(8'hff, 8'hff);
		check("dummy", 8'(dummy_cycles_o), 8'd18);
		check("flags", 8'({read_crc_disable_o, program_crc_disable_o, error_pin_event_select_o,
			error_pin_disable_o, correction_disable_o}), 8'h1f);
		$display("test reset done");
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		rst_n_i = 1'b0;
		train_read_i = 1'b0;
		train_bit_i = 3'h0;
		ecc_corr_i = 1'b0;
		ecc_detect_i = 1'b0;
		reset_check();
		for (int i = 0; i < 4; i++) begin
			wcfg(8'h00, MODES[i]);
			check("mode", 8'({octal_ddr_o, strobe_en_o}), MOUT[i]);
			check("boot mode", 8'({boot_octal_o, boot_strobe_o}), 8'h03);
			rcfg(8'h00, MODES[i]);
			wcfg(8'h01, DCODE[i]);
			check("dummy", 8'(dummy_cycles_o), DCYC[i]);
			@(posedge clk_i);
			train_read_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			#1;
			check("train dummy", 8'(dummy_cycles_o), DCYC[i] + 8'd2);
			@(posedge clk_i);
			train_read_i <= 1'b0;
			wcfg(8'h07, WCODE[i]);
			check("wrap", 8'(wrap_bytes_o), WLEN[i]);
		end
		wcfg(8'h05, 8'hfe);
		check("four byte", 8'(four_byte_addr_o), 8'h01);
		wcfg(8'h06, 8'hfe);
		check("xip", 8'(execute_in_place_o), 8'h01);
		wcfg(8'h03, 8'hfc);
		check("drive", 8'(drive_sel_o), 8'h03);
		rcfg(8'h03, 8'hfc);
		$display("test settings done");
		k = n_rej;
		wcfg(8'h02, 8'h00);
		wcfg(8'h01, 8'h20);
		wcfg(8'h05, 8'h12);
		wcfg(8'h00, 8'h3c);
		check("rejects", 8'(n_rej - k), 8'h04);
		rcfg(8'h02, 8'hff);
		rcfg(8'h01, 8'h1f);
		rcfg(8'h05, 8'hfe);
		rcfg(8'h00, 8'hc7);
		$display("test reserved done");
		v = 8'ha5;
		wcfg(8'h0a, v);
		rcfg(8'h0a, v);
		for (int s = 0; s < 2; s++) begin
			wcfg(8'h0b, s ? 8'hbf : 8'hff);
			for (int b = 0; b < 8; b++) begin
				@(posedge clk_i);
				train_bit_i <= 3'(b);
				repeat (2) @(posedge clk_i);
				#1;
				check("lanes", train_dq_o, {8{v[7-b]}} ^ (s ? 8'h08 : 8'h00));
			end
		end
		for (int f = 0; f < 4; f++) begin
			wcfg(8'h0b, {1'(f), 1'b1, 2'(f), 4'h0});
			check("chunk", program_chunk_size_o, 8'h80 >> f);
			check("flags", 8'({read_crc_disable_o, program_crc_disable_o,
				error_pin_event_select_o, error_pin_disable_o, correction_disable_o}),
				{3'h0, 1'(f), 4'h0});
		end
		$display("test integrity done");
		wcfg(8'h0b, 8'hf8);
		k = n_err;
		ev(1'b0, 1'b1);
		for (int i = 0; i < 17; i++)
			ev(1'b1, 1'b0);
		check("err pulses", 8'(n_err - k), 8'd17);
		check("counter", 8'(correction_event_counter_o), 8'h0f);
		rcfg(8'h0c, 8'h78);
		for (int i = 0; i < 3; i++) begin
			wcfg(8'h0b, ECODE[i]);
			k = n_err;
			ev(1'b1, 1'b0);
			ev(1'b1, 1'b0);
			ev(1'b0, 1'b1);
			check("err select", 8'(n_err - k), EHIT[i]);
		end
		$display("test ecc done");
		reset_check();
		stop_test();
	end
endmodule
